// file: hw/fsr_bank.sv
// Purpose : boost and led fault status registers with interrupt output
// Assumes : fault events and register accesses come from same-clock logic
// Notes   : a flag is cleared only by writing one to it and its clear bit
//
// How it works
// - a thermal fault sets bit 15 of the boost register, zero is no fault.
// - a flag is acknowledged only by one written to it and its clear bit.
// - an acknowledge clears the stored flag and its share of the interrupt.
// - a shorted current resistor shows at bit 13, acknowledged at bit 12.
// - a missing string resistor shows at bit 11, acknowledged at bit 10.
// - a missing mode resistor shows at bit 9, acknowledged at bit 8.
// - a missing frequency resistor shows at bit 7, acknowledged at bit 6.
// - a boost over-current shows at bit 5, acknowledged at bit 4.
// - a high over-voltage shows at bit 3, acknowledged at bit 2.
// - a low over-voltage shows at bit 1, acknowledged at bit 0.
// - the boost register sits at 10h and resets to all zeros.
// - the led register sits at 12h, resets to zero, holds three flags.
// - its low four bits are read-only fault states of channels 4 to 1.
// - ground short, internal short and open states clear with the lamp summary ack.
module fsr_bank (
    input  wire logic                       clock,
    input  wire logic                       reset_n,
    input  wire logic [fsr_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    input  wire logic [fsr_pkg::DATA_W-1:0] reg_wdata,
    output logic      [fsr_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic [7:0]                 boost_fault_evt,
    input  wire logic [2:0]                 led_fault_evt,
    input  wire logic [2:0]                 lamp_evt,
    input  wire logic [3:0]                 channel_fault,
    input  wire logic [7:0]                 boost_irq_en,
    input  wire logic [2:0]                 led_irq_en,
    output logic                            fault_irq
);
    import fsr_pkg::*;

    // ****************************************************************
    // reset release
    // ****************************************************************
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ****************************************************************
    // address decode
    // ****************************************************************
    logic boost_sel;
    logic led_sel;
    logic boost_wr;
    logic led_wr;

    assign boost_sel = (reg_addr == BOOST_OFFSET);
    assign led_sel   = (reg_addr == LED_OFFSET);
    assign boost_wr  = reg_wr && boost_sel;
    assign led_wr    = reg_wr && led_sel;

    // ****************************************************************
    // acknowledge decode
    // ****************************************************************
    logic [BOOST_FLAGS-1:0] boost_ack;
    logic [LED_FLAGS-1:0]   led_ack;

    for (genvar i = 0; i < BOOST_FLAGS; i++) begin : g_boost_ack
        assign boost_ack[i] = boost_wr
                              && reg_wdata[BOOST_FLAG_POS[i]]
                              && reg_wdata[BOOST_ACK_POS[i]];
    end
    for (genvar j = 0; j < LED_FLAGS; j++) begin : g_led_ack
        assign led_ack[j] = led_wr
                            && reg_wdata[LED_FLAG_POS[j]]
                            && reg_wdata[LED_ACK_POS[j]];
    end

    // ****************************************************************
    // sticky flags
    // ****************************************************************
    fsr_flag_if #(.N(BOOST_FLAGS)) boost_if ();
    fsr_flag_if #(.N(LED_FLAGS))   led_if ();
    fsr_flag_if #(.N(LAMP_INDS))   lamp_if ();

    assign boost_if.set = boost_fault_evt;
    assign boost_if.clr = boost_ack;
    assign led_if.set   = led_fault_evt;
    assign led_if.clr   = led_ack;
    assign lamp_if.set  = lamp_evt;
    assign lamp_if.clr  = {LAMP_INDS{led_ack[LAMP_IDX]}};

    fsr_sticky #(.N(BOOST_FLAGS)) u_boost_flags (
        .clock (clock),
        .rst_n (rst_n),
        .flags (boost_if.keeper)
    );
    fsr_sticky #(.N(LED_FLAGS)) u_led_flags (
        .clock (clock),
        .rst_n (rst_n),
        .flags (led_if.keeper)
    );
    fsr_sticky #(.N(LAMP_INDS)) u_lamp_inds (
        .clock (clock),
        .rst_n (rst_n),
        .flags (lamp_if.keeper)
    );

    // channel states are live levels, copied once for a clean read
    logic [CHANNELS-1:0] channel_ind;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            channel_ind <= '0;
        end else begin
            channel_ind <= channel_fault;
        end
    end

    // ****************************************************************
    // read words
    // ****************************************************************
    logic [DATA_W-1:0] boost_word;
    logic [DATA_W-1:0] led_word;
    logic [DATA_W-1:0] next_rdata;

    for (genvar i = 0; i < BOOST_FLAGS; i++) begin : g_boost_word
        assign boost_word[BOOST_FLAG_POS[i]] = boost_if.flag[i];
        // clear bits act only on write and read back as zero
        assign boost_word[BOOST_ACK_POS[i]]  = 1'b0;
    end

    assign led_word[RESERVED_POS] = 1'b0;
    for (genvar j = 0; j < LED_FLAGS; j++) begin : g_led_word
        assign led_word[LED_FLAG_POS[j]] = led_if.flag[j];
        assign led_word[LED_ACK_POS[j]]  = 1'b0;
    end
    assign led_word[GROUND_POS:OPEN_POS] = lamp_if.flag;
    assign led_word[OPEN_POS-1:CHANNELS] = '0;
    assign led_word[CHANNELS-1:0]        = channel_ind;

    // unmapped addresses read as zero
    assign next_rdata = boost_sel ? boost_word
                      : led_sel   ? led_word
                      : REG_RESET;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= REG_RESET;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // ****************************************************************
    // interrupt output
    // ****************************************************************
    logic [BOOST_FLAGS+LED_FLAGS-1:0] pending;
    logic                             next_irq;

    assign pending  = {led_if.flag & led_irq_en,
                       boost_if.flag & boost_irq_en};
    assign next_irq = |pending;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fault_irq <= 1'b0;
        end else begin
            fault_irq <= next_irq;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic no_events;
    logic [BOOST_FLAGS+LED_FLAGS-1:0] acked;

    assign no_events = (boost_fault_evt == '0) && (led_fault_evt == '0);
    assign acked     = {led_ack, boost_ack};

    sequence s_last_ack;
        next_irq && ((pending & ~acked) == '0) && no_events;
    endsequence

    sequence s_quiet_after;
        no_events [*2];
    endsequence

    a_thermal_sets_flag: assert property (
        boost_fault_evt[THERMAL_IDX] |=> boost_if.flag[THERMAL_IDX])
        else $error("thermal event did not set its flag");

    a_pair_clears_flag: assert property (
        boost_ack[CUR_RES_IDX] && !boost_fault_evt[CUR_RES_IDX]
        |=> !boost_if.flag[CUR_RES_IDX])
        else $error("paired write did not clear the flag");

    a_ack_drops_irq: assert property (
        (s_last_ack ##0 s_quiet_after) |-> ##2 !fault_irq)
        else $error("interrupt held after the last acknowledge");

    a_irq_tracks_flags: assert property (
        fault_irq == $past(next_irq))
        else $error("interrupt does not follow enabled flags");

    a_half_write_keeps: assert property (
        boost_wr && reg_wdata[BOOST_FLAG_POS[OCP_IDX]]
        && !reg_wdata[BOOST_ACK_POS[OCP_IDX]] && boost_if.flag[OCP_IDX]
        |=> boost_if.flag[OCP_IDX])
        else $error("write without clear bit changed a flag");

    a_boost_read_map: assert property (
        reg_rd && boost_sel |=>
        reg_rdata[13] == $past(boost_if.flag[CUR_RES_IDX])
        && reg_rdata[1] == $past(boost_if.flag[OVP_LOW_IDX])
        && (reg_rdata & 16'h5555) == 16'h0000)
        else $error("boost register read does not match the flags");

    a_reset_clears_all: assert property (
        $rose(rst_n) |-> boost_if.flag == '0 && led_if.flag == '0)
        else $error("flags not clear after reset");

    a_led_read_map: assert property (
        reg_rd && led_sel |=>
        reg_rdata[14] == $past(led_if.flag[TIMEOUT_IDX])
        && (reg_rdata & 16'haa30) == 16'h0000)
        else $error("led register read does not match the flags");

    a_channel_readback: assert property (
        reg_rd && led_sel |=> reg_rdata[3:0] == $past(channel_ind))
        else $error("channel fault bits read back wrong");

    a_lamp_clear_ack: assert property (
        led_ack[LAMP_IDX] && lamp_evt == '0 |=> lamp_if.flag == '0)
        else $error("lamp states not cleared with summary ack");

    // an event in the clearing cycle is excused, set wins there
    a_boost_acks_all: assert property (
        (boost_ack & ~boost_fault_evt) != '0
        |=> (boost_if.flag & $past(boost_ack & ~boost_fault_evt)) == '0)
        else $error("boost acknowledge left a flag set");

    a_led_acks_all: assert property (
        (led_ack & ~led_fault_evt) != '0
        |=> (led_if.flag & $past(led_ack & ~led_fault_evt)) == '0)
        else $error("led acknowledge left a flag set");

    a_boost_sets_flag: assert property (
        boost_fault_evt != '0 |=>
        (boost_if.flag & $past(boost_fault_evt)) == $past(boost_fault_evt))
        else $error("boost fault event did not set its flag");

    a_led_sets_flag: assert property (
        led_fault_evt != '0 |=>
        (led_if.flag & $past(led_fault_evt)) == $past(led_fault_evt))
        else $error("led fault event did not set its flag");

    a_lamp_sets_ind: assert property (
        lamp_evt != '0 |=>
        (lamp_if.flag & $past(lamp_evt)) == $past(lamp_evt))
        else $error("lamp event did not set its indicator");

    // read data must stand until the host asks again
    a_rdata_holds: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    a_unmapped_zero: assert property (
        reg_rd && !boost_sel && !led_sel |=> reg_rdata == '0)
        else $error("unmapped address did not read zero");

    a_reserved_zero: assert property (
        reg_rd && led_sel |=> !reg_rdata[RESERVED_POS])
        else $error("reserved led bit read back as one");

    // one bit of the pair alone must not touch the summary flag
    a_led_half_write: assert property (
        led_wr && (reg_wdata[LED_FLAG_POS[LAMP_IDX]]
                   != reg_wdata[LED_ACK_POS[LAMP_IDX]])
        && led_if.flag[LAMP_IDX] |=> led_if.flag[LAMP_IDX])
        else $error("led half write changed the summary flag");

    a_irq_low_idle: assert property (
        pending == '0 |=> !fault_irq)
        else $error("interrupt high with no enabled flag set");

    // first cycle after reset is skipped, the copy was held clear
    a_channel_copy: assert property (
        $past(rst_n) |-> channel_ind == $past(channel_fault))
        else $error("channel fault copy lags more than a cycle");

endmodule : fsr_bank

// file: hw/fsr_flag_if.sv
// Purpose : carries set, clear and state of a group of sticky flags
// Assumes : all signals on the one system clock
// Notes   : keeper holds the flags, user raises sets and clears
interface fsr_flag_if #(
    parameter int unsigned N = 8
) ();
    logic [N-1:0] set;
    logic [N-1:0] clr;
    logic [N-1:0] flag;

    modport keeper (
        input  set,
        input  clr,
        output flag
    );
    modport user (
        output set,
        output clr,
        input  flag
    );
endinterface : fsr_flag_if

// file: hw/fsr_pkg.sv
// Purpose : constants shared by the fault status register bank
// Assumes : one 40 MHz clock, registers reached over a simple word port
// Notes   : positions are bit numbers inside the 16-bit registers
package fsr_pkg;

    // ****************************************************************
    // register port
    // ****************************************************************
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned DATA_W       = 16;
    localparam logic [7:0]  BOOST_OFFSET = 8'h10;
    localparam logic [7:0]  LED_OFFSET   = 8'h12;
    localparam logic [15:0] REG_RESET    = 16'h0000;

    // ****************************************************************
    // boost fault flags, index 7 down to 0
    // ****************************************************************
    localparam int unsigned BOOST_FLAGS  = 8;
    localparam int unsigned THERMAL_IDX  = 7;
    localparam int unsigned CUR_RES_IDX  = 6;
    localparam int unsigned STR_RES_IDX  = 5;
    localparam int unsigned MODE_RES_IDX = 4;
    localparam int unsigned FREQ_RES_IDX = 3;
    localparam int unsigned OCP_IDX      = 2;
    localparam int unsigned OVP_HIGH_IDX = 1;
    localparam int unsigned OVP_LOW_IDX  = 0;
    localparam logic [7:0][3:0] BOOST_FLAG_POS =
        {4'hf, 4'hd, 4'hb, 4'h9, 4'h7, 4'h5, 4'h3, 4'h1};
    localparam logic [7:0][3:0] BOOST_ACK_POS =
        {4'he, 4'hc, 4'ha, 4'h8, 4'h6, 4'h4, 4'h2, 4'h0};

    // ****************************************************************
    // led fault flags, index 2 down to 0
    // ****************************************************************
    localparam int unsigned LED_FLAGS    = 3;
    localparam int unsigned TIMEOUT_IDX  = 2;
    localparam int unsigned BAD_STR_IDX  = 1;
    localparam int unsigned LAMP_IDX     = 0;
    localparam logic [2:0][3:0] LED_FLAG_POS = {4'he, 4'hc, 4'ha};
    localparam logic [2:0][3:0] LED_ACK_POS  = {4'hd, 4'hb, 4'h9};

    // lamp indicators: ground short, internal short, open
    localparam int unsigned LAMP_INDS    = 3;
    localparam int unsigned GROUND_IND   = 2;
    localparam int unsigned SHORT_IND    = 1;
    localparam int unsigned OPEN_IND     = 0;
    localparam int unsigned GROUND_POS   = 8;
    localparam int unsigned OPEN_POS     = 6;
    localparam int unsigned CHANNELS     = 4;
    localparam int unsigned RESERVED_POS = 15;

endpackage : fsr_pkg

// file: hw/fsr_sticky.sv
// Purpose : group of sticky flags, set by events, cleared on request
// Assumes : reset already synchronised by the caller
// Notes   : a set in the clearing cycle wins, so no event is lost
module fsr_sticky #(
    parameter int unsigned N = 8
) (
    input  wire logic clock,
    input  wire logic rst_n,
    fsr_flag_if.keeper flags
);
    import fsr_pkg::*;

    logic [N-1:0] next_flag;

    assign next_flag = (flags.flag & ~flags.clr) | flags.set;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flags.flag <= '0;
        end else begin
            flags.flag <= next_flag;
        end
    end

    a_flag_stays_set: assert property (
        @(posedge clock) disable iff (!rst_n)
        (flags.flag != '0) |=> ((flags.flag | $past(flags.clr))
                                 & $past(flags.flag)) == $past(flags.flag))
        else $error("sticky flag dropped without a clear");

endmodule : fsr_sticky

// file: verification/fsr_bank_tb_top.sv
// Purpose : self-checking bench of the fault status register bank
// Assumes : 40 MHz clock, inputs driven on the falling edge
// Notes   : a shadow of every flag predicts reads and the interrupt
module fsr_bank_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  reg_addr, boost_fault_evt = 8'h00, boost_irq_en = 8'h00;
    logic        reg_wr, reg_rd, fault_irq;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [2:0]  led_fault_evt = 3'h0, lamp_evt = 3'h0, led_irq_en = 3'h0;
    logic [3:0]  channel_fault = 4'h0;
    logic [7:0]  mb = 8'h00;
    logic [2:0]  ml = 3'h0, mlamp = 3'h0;
    logic [31:0] r, r2;
    int          err_total = 0, check_count = 0, seed = 32'hb4de;
    logic [7:0]  addr_tab [4] = '{8'h10, 8'h12, 8'h14, 8'h11};

    always #12.5 clock = ~clock;

    fsr_bank dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .boost_fault_evt(boost_fault_evt),
        .led_fault_evt(led_fault_evt), .lamp_evt(lamp_evt),
        .channel_fault(channel_fault), .boost_irq_en(boost_irq_en),
        .led_irq_en(led_irq_en), .fault_irq(fault_irq));
    fsr_host_model host (.clock(clock), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));

    // ****************************************************************
    // expectations and checks
    // ****************************************************************
    function automatic logic [15:0] exp_boost();
        logic [15:0] e;
        e = 16'h0000;
        for (int i = 0; i < 8; i++) e[2*i+1] = mb[i];
        return e;
    endfunction : exp_boost

    function automatic logic [15:0] exp_led();
        logic [15:0] e;
        e = 16'h0000;
        for (int j = 0; j < 3; j++) e[10+2*j] = ml[j];
        e[8:6] = mlamp;
        e[3:0] = channel_fault;
        return e;
    endfunction : exp_led

    task automatic cmp(input string n, input logic [15:0] e, g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : cmp

    task automatic check_regs();
        logic [15:0] v;
        host.rd(8'h10, v);
        cmp("boost", exp_boost(), v);
        host.rd(8'h12, v);
        cmp("led", exp_led(), v);
        cmp("irq", {15'h0000, |({mb, ml} & {boost_irq_en, led_irq_en})},
            {15'h0000, fault_irq});
    endtask : check_regs

    // events and an optional write in the same cycle; set beats clear
    task automatic act(input logic [7:0] b, input logic [2:0] l, lp,
                       input logic w, input logic [7:0] a,
                       input logic [15:0] v);
        fork
            if (w) host.wr(a, v);
            begin
                @(negedge clock);
                boost_fault_evt = b;
                led_fault_evt   = l;
                lamp_evt        = lp;
                @(negedge clock);
                boost_fault_evt = 8'h00;
                led_fault_evt   = 3'h0;
                lamp_evt        = 3'h0;
            end
        join
        for (int i = 0; i < 8; i++)
            if (w && a == 8'h10 && v[2*i+1] && v[2*i]) mb[i] = 1'b0;
        for (int j = 0; j < 3; j++)
            if (w && a == 8'h12 && v[10+2*j] && v[9+2*j]) begin
                ml[j] = 1'b0;
                if (j == 0) mlamp = 3'h0;
            end
        mb    = mb | b;
        ml    = ml | l;
        mlamp = mlamp | lp;
    endtask : act

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        test_done();
    end

    initial begin
        repeat (8) @(posedge clock);
        @(negedge clock);
        reset_n = 1'b1;
        repeat (3) @(negedge clock);
        boost_irq_en = 8'hff;
        led_irq_en   = 3'h7;
        check_regs();
        host.rd(8'h14, d);
        cmp("unmapped", 16'h0000, d);
        $display("test reset done, errors %0d", err_total);
        for (int i = 0; i < 8; i++) begin
            act(8'h01 << i, 3'h0, 3'h0, 1'b0, 8'h00, 16'h0000);
            check_regs();
            act(8'h00, 3'h0, 3'h0, 1'b1, 8'h10, 16'h0002 << 2*i);
            act(8'h00, 3'h0, 3'h0, 1'b1, 8'h10, 16'h0001 << 2*i);
            check_regs();
            act(8'h00, 3'h0, 3'h0, 1'b1, 8'h10, 16'h0003 << 2*i);
            check_regs();
        end
        $display("test boost done, errors %0d", err_total);
        for (int j = 0; j < 3; j++) begin
            channel_fault = 4'h1 << j;
            act(8'h00, 3'h1 << j, 3'h7, 1'b0, 8'h00, 16'h0000);
            check_regs();
            act(8'h00, 3'h0, 3'h0, 1'b1, 8'h12, 16'h05ff << 2*j);
            act(8'h00, 3'h0, 3'h0, 1'b1, 8'h12, 16'h0200 << 2*j);
            check_regs();
            act(8'h00, 3'h0, 3'h0, 1'b1, 8'h12, 16'h0600 << 2*j);
            check_regs();
        end
        $display("test led done, errors %0d", err_total);
        for (int k = 0; k < 60; k++) begin
            r  = $random(seed);
            r2 = $random(seed);
            boost_irq_en  = r[7:0];
            led_irq_en    = r[10:8];
            channel_fault = r[14:11];
            d = r2[31:16];
            if (r[21])
                d = d | (16'h0003 << 2*r[18:16]) | (16'h0600 << 2*(k%3));
            act(r2[7:0] & r2[15:8], r2[2:0] & r2[5:3], r2[10:8] & r2[13:11],
                r[31], addr_tab[r[20:19]], d);
            check_regs();
        end
        $display("test random done, errors %0d", err_total);
        test_done();
    end
endmodule : fsr_bank_tb_top

// file: verification/fsr_host_model.sv
// Purpose : host side of the fault register port, word reads and writes
// Assumes : inputs of the bank are sampled on the rising clock edge
// Notes   : address is scrambled after each strobe, data after each write
module fsr_host_model (
    input  wire logic        clock,
    output logic      [7:0]  reg_addr,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [15:0] reg_wdata,
    input  wire logic [15:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 16'h0000;
    end

    // pair bits go in one write
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clock);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clock);
        reg_wr    = 1'b0;
        reg_wdata = ~d;
        reg_addr  = ~a;
    endtask : wr

    // data holds until the next read, so it is taken a full cycle late
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clock);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        @(negedge clock);
        d = reg_rdata;
    endtask : rd
endmodule : fsr_host_model
